// ---- pc_card_pkg.sv ----
// Constants shared by the card-mode host interface decoder.
// Assumes one 200 MHz core clock and host strobes already synchronous.
package pc_card_pkg;
    // Host bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int REG_ADDR_W = 5;
    // Configuration registers in attribute space (byte addresses)
    localparam logic [15:0] CARD_CONFIG_OPTION_OFS = 16'h03f0;
    localparam logic [15:0] CARD_CONFIG_REG_1_OFS = 16'h03f2;
    localparam logic [15:0] CARD_CONFIG_REG_2_OFS = 16'h03f4;
    localparam logic [15:0] CARD_CONFIG_REG_3_OFS = 16'h03f6;
    localparam int CCR_COUNT = 4;
    localparam logic [7:0] CCR_RESET = 8'h00;
    // Fields of the first configuration register
    localparam int CFG_INDEX_LSB = 0;
    localparam int CFG_INDEX_W = 6;
    localparam int IO_ENABLE_BIT = 0;
    // ISA interrupt lines; one of them carries the SRAM select in card mode
    localparam int ISA_IRQ_W = 8;
    localparam int SRAM_CS_IRQ_IDX = 1;
    localparam logic [7:0] IRQ_ALL_OFF = 8'hff;
    localparam logic [7:0] IRQ_ALL_ON = 8'h00;
endpackage

// ---- pc_card_host_interface_decode.sv ----
// Card-mode host interface decode: memory spaces, configuration registers,
// I/O gating, flash and SRAM selection, pin reassignment.
// Assumes host strobes are synchronous to core_clk and a core supplies data.
`timescale 1ns/100ps
module pc_card_host_interface_decode
    import pc_card_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Straps and static configuration
    input wire logic cardModeStrap,
    input wire logic sharedMemMode,
    input wire logic sharedMemMatch,
    input wire logic flashWriteEnable,
    input wire logic eepromPresent,
    input wire logic sleep_n,
    input wire logic netTpSelect,
    // Host card bus
    input wire logic [ADDR_W-1:0] hostAddr,
    input wire logic [DATA_W-1:0] hostDataIn,
    output logic [DATA_W-1:0] hostDataOut,
    output logic hostDataOe_n,
    input wire logic ce1_n,
    input wire logic ce2_n,
    input wire logic regSel_n,
    input wire logic memRd_n,
    input wire logic memWr_n,
    input wire logic ioRd_n,
    input wire logic ioWr_n,
    output logic waitOut_n,
    output logic waitOe_n,
    output logic iois16Out_n,
    output logic iois16Oe_n,
    output logic inpack_n,
    output logic cardIreq_n,
    // ISA interrupt lines
    output logic [ISA_IRQ_W-1:0] isaIrqOut,
    output logic [ISA_IRQ_W-1:0] isaIrqOe_n,
    // Core side
    input wire logic [ISA_IRQ_W-1:0] isaIrqReq,
    input wire logic irqReq,
    input wire logic coreReady,
    input wire logic isaIo16Req,
    input wire logic isaNotReady,
    input wire logic [DATA_W-1:0] ioRdData,
    output logic [REG_ADDR_W-1:0] ioRegAddr,
    output logic ioRdActive,
    output logic ioWrStb,
    output logic [DATA_W-1:0] ioWrData,
    output logic cfgLoadEn,
    output logic sleepReq,
    output logic tpActive,
    output logic auiActive,
    output logic cardMode,
    output logic ioEnable,
    // Local flash and SRAM
    input wire logic [DATA_W-1:0] localRdData,
    output logic [ADDR_W-1:0] localAddr,
    output logic flashCs_n,
    output logic flashWe_n,
    output logic sramCs_n,
    output logic sramWe_n,
    output logic localOe_n
);

    // Is this byte address inside the configuration register window
    function automatic logic ccrHitF(input logic [ADDR_W-1:0] a);
        ccrHitF = (a[ADDR_W-1:3] == CARD_CONFIG_OPTION_OFS[ADDR_W-1:3]);
    endfunction

    // Which configuration register an even byte address points at
    function automatic logic [1:0] ccrIdxF(input logic [ADDR_W-1:0] a);
        ccrIdxF = a[2:1];
    endfunction

    logic rstMeta_r;
    logic rstSync_n;
    logic strapDone_r;
    logic cardMode_r;
    logic [7:0] ccr_r [0:CCR_COUNT-1];
    logic memWrLast_r;
    logic ioWrLast_r;
    logic [DATA_W-1:0] hostDataOut_r;
    logic [DATA_W-1:0] hostDataOut_nxt;
    logic tpActive_r;
    logic auiActive_r;

    // Reset release through two flops; async assert, sync release
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_r <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_n <= rstMeta_r;
        end
    end

    // Strap is caught once in the first cycle after reset is released
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            strapDone_r <= 1'b0;
            cardMode_r <= 1'b0;
        end else if (!strapDone_r) begin
            strapDone_r <= 1'b1;
            cardMode_r <= cardModeStrap;
        end
    end
    assign cardMode = cardMode_r;

    // Shared-memory match is a board input; tie-high in I/O mode is external
    wire sharedMemMatchIn;
    assign sharedMemMatchIn = sharedMemMatch;

    // Host cycle decode
    wire ceAny = ~ce1_n | ~ce2_n;
    wire memCyc = cardMode_r & ceAny & (~memRd_n | ~memWr_n);
    wire ioCyc = cardMode_r & ceAny & (~ioRd_n | ~ioWr_n);
    wire attrCyc = memCyc & ~regSel_n;
    wire commonCyc = memCyc & regSel_n;
    wire attrOdd = hostAddr[0];
    wire ccrSel = attrCyc & ccrHitF(hostAddr) & ~attrOdd;
    wire [1:0] ccrIdx = ccrIdxF(hostAddr);
    // Odd attribute bytes select nothing, so their reads leave the data bus undriven
    wire attrFlashSel = attrCyc & ~ccrHitF(hostAddr) & ~attrOdd;
    wire commonFlashSel = commonCyc & sharedMemMatchIn;
    wire sramSel = commonCyc & ~sharedMemMatchIn & sharedMemMode;
    wire flashSel = attrFlashSel | commonFlashSel;
    wire memRdSel = (ccrSel | flashSel | sramSel) & ~memRd_n;

    // Write strobes fire on the falling edge of the host write strobe
    wire ccrWrStb = ccrSel & ~memWr_n & memWrLast_r;
    wire ioWrEdge = ~ioWr_n & ioWrLast_r;

    // I/O answers only after the host enabled them
    assign ioEnable = ccr_r[0][IO_ENABLE_BIT];
    wire ioGo = ioCyc & ioEnable;
    assign ioRdActive = ioGo & ~ioRd_n;
    assign ioWrStb = ioGo & ioWrEdge;
    assign ioRegAddr = hostAddr[REG_ADDR_W-1:0];
    assign ioWrData = hostDataIn;

    // Strobe history for edge detection
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            memWrLast_r <= 1'b1;
            ioWrLast_r <= 1'b1;
        end else begin
            memWrLast_r <= memWr_n;
            ioWrLast_r <= ioWr_n;
        end
    end

    // Configuration registers; a fitted EEPROM preloads via the core
    // during reset, so here they simply clear to the unconfigured state
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            for (int i = 0; i < CCR_COUNT; i++) begin
                ccr_r[i] <= CCR_RESET;
            end
        end else if (ccrWrStb) begin
            ccr_r[ccrIdx] <= hostDataIn[7:0];
        end
    end

    // Read data source; registered so data outputs come from flops
    always_comb begin
        hostDataOut_nxt = '0;
        if (ccrSel) begin
            hostDataOut_nxt = {8'h00, ccr_r[ccrIdx]};
        end else if (attrFlashSel) begin
            hostDataOut_nxt = {8'h00, localRdData[7:0]};
        end else if (commonFlashSel | sramSel) begin
            hostDataOut_nxt = localRdData;
        end else if (ioRdActive) begin
            hostDataOut_nxt = ioRdData;
        end
    end

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            hostDataOut_r <= '0;
        end else begin
            hostDataOut_r <= hostDataOut_nxt;
        end
    end
    assign hostDataOut = hostDataOut_r;
    // Data bus driven only for decoded reads; disabled I/O stays off
    assign hostDataOe_n = ~(memRdSel | ioRdActive);

    // Ready: push-pull in card mode, open drain in ISA; 16-bit indication is only ever driven low, in both modes
    wire cardDrive = memCyc | ioGo;
    assign waitOut_n = cardMode_r ? coreReady : 1'b0;
    assign waitOe_n = cardMode_r ? ~cardDrive : ~isaNotReady;
    assign iois16Out_n = 1'b0;
    assign iois16Oe_n = cardMode_r ? ~ioGo : ~isaIo16Req;
    assign inpack_n = ~ioRdActive;
    assign cardIreq_n = ~(cardMode_r & irqReq);

    // Local memory strobes; flash writes gated by the write enable bit
    assign localAddr = hostAddr;
    assign flashCs_n = ~flashSel;
    assign flashWe_n = ~(flashSel & ~memWr_n & flashWriteEnable);
    assign sramCs_n = ~sramSel;
    assign sramWe_n = ~(sramSel & ~memWr_n);
    assign localOe_n = ~(memRdSel & ~ccrSel);

    // Pin reassignment: IRQ lines released in card mode except SRAM select
    always_comb begin
        isaIrqOut = isaIrqReq;
        isaIrqOe_n = cardMode_r ? IRQ_ALL_OFF : IRQ_ALL_ON;
        if (cardMode_r) begin
            isaIrqOut[SRAM_CS_IRQ_IDX] = sramCs_n;
            isaIrqOe_n[SRAM_CS_IRQ_IDX] = 1'b0;
        end
    end

    // EEPROM load window is the reset itself; absent EEPROM is legal
    assign cfgLoadEn = eepromPresent & ~rstSync_n;
    // Sleep works in both modes
    assign sleepReq = ~sleep_n;

    // Network port choice; registered so exactly one is ever active
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            tpActive_r <= 1'b1;
            auiActive_r <= 1'b0;
        end else begin
            tpActive_r <= netTpSelect;
            auiActive_r <= ~netTpSelect;
        end
    end
    assign tpActive = tpActive_r;
    assign auiActive = auiActive_r;

    // Checks on the decode
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstSync_n);

    property p_strapHeld;
        strapDone_r |=> $stable(cardMode_r);
    endproperty
    a_strapHeld: assert property (p_strapHeld)
        else $error("card mode changed after strap capture");

    property p_irqReleased;
        cardMode_r |-> isaIrqOe_n[0] && !isaIrqOe_n[SRAM_CS_IRQ_IDX]
            && isaIrqOut[SRAM_CS_IRQ_IDX] == sramCs_n;
    endproperty
    a_irqReleased: assert property (p_irqReleased)
        else $error("interrupt pins not reassigned in card mode");

    property p_pushPull;
        ioGo |-> !waitOe_n && !iois16Oe_n && waitOut_n == coreReady;
    endproperty
    a_pushPull: assert property (p_pushPull)
        else $error("card mode ready or io16 not driven");

    property p_memOnlyAfterReset;
        $rose(strapDone_r) |-> !ioEnable ##1 (!ioEnable || $past(ccrWrStb));
    endproperty
    a_memOnlyAfterReset: assert property (p_memOnlyAfterReset)
        else $error("I/O enabled right after reset");

    property p_attrNoSram;
        attrCyc |-> sramCs_n;
    endproperty
    a_attrNoSram: assert property (p_attrNoSram)
        else $error("SRAM selected during attribute access");

    property p_oddIgnored;
        attrCyc && attrOdd && !memWr_n |=> $stable(ccr_r[0]) && flashCs_n;
    endproperty
    a_oddIgnored: assert property (p_oddIgnored)
        else $error("odd attribute write took effect");

    property p_ccrWrite;
        ccrWrStb && ccrIdx == 2'd0 |=> ccr_r[0] == $past(hostDataIn[7:0]);
    endproperty
    a_ccrWrite: assert property (p_ccrWrite)
        else $error("configuration register write lost");

    property p_ioGated;
        ioWrStb || ioRdActive |-> ccr_r[0][IO_ENABLE_BIT];
    endproperty
    a_ioGated: assert property (p_ioGated)
        else $error("I/O answered while disabled");

    property p_ioQuiet;
        ioCyc && !memCyc && !ioEnable |-> hostDataOe_n && waitOe_n
            && iois16Oe_n && inpack_n;
    endproperty
    a_ioQuiet: assert property (p_ioQuiet)
        else $error("bus driven in disabled I/O cycle");

    property p_flashSelect;
        commonCyc && sharedMemMatchIn |-> !flashCs_n && sramCs_n;
    endproperty
    a_flashSelect: assert property (p_flashSelect)
        else $error("common memory match did not select flash");

    property p_flashWrGate;
        !flashWriteEnable |-> flashWe_n;
    endproperty
    a_flashWrGate: assert property (p_flashWrGate)
        else $error("flash written without write enable");

    property p_onePort;
        tpActive != auiActive;
    endproperty
    a_onePort: assert property (p_onePort)
        else $error("network ports not one-hot");

    property p_readData;
        ccrSel && !memRd_n |=> hostDataOut[7:0] == $past(ccr_r[ccrIdx]);
    endproperty
    a_readData: assert property (p_readData)
        else $error("configuration register read back wrong");

    property p_isaOpenDrain;
        !cardMode_r |-> !waitOut_n && !iois16Out_n;
    endproperty
    a_isaOpenDrain: assert property (p_isaOpenDrain)
        else $error("ISA ready or io16 pin value not low");

    property p_sramSelect;
        commonCyc && !sharedMemMatchIn && sharedMemMode |-> !sramCs_n
            && flashCs_n;
    endproperty
    a_sramSelect: assert property (p_sramSelect)
        else $error("shared memory miss did not select SRAM");

    property p_attrByteWide;
        attrFlashSel && !memRd_n |=> hostDataOut[15:8] == 8'h00;
    endproperty
    a_attrByteWide: assert property (p_attrByteWide)
        else $error("attribute read drove the upper byte");

    c_ccrWrite: cover property (ccrWrStb ##[1:20] ioWrStb);
    c_flashRead: cover property (attrFlashSel && !memRd_n);
    c_sramWrite: cover property (!sramWe_n);
    c_flashWrite: cover property (!flashWe_n);

endmodule

// ---- pc_card_host_model.sv ----
// Host socket controller model: runs one card cycle at a time.
// Assumes the bench calls access() and samples the card while obsValid.
`timescale 1ns/100ps
module pc_card_host_model (
    // Clock
    input wire logic core_clk,
    // Socket address, data and strobes
    output logic [15:0] hostAddr,
    output logic [15:0] hostDataIn,
    output logic ce1_n,
    output logic ce2_n,
    output logic regSel_n,
    output logic memRd_n,
    output logic memWr_n,
    output logic ioRd_n,
    output logic ioWr_n,
    // High in the cycle before release, when the answer has settled
    output logic obsValid
);
    // Idle socket: nothing selected, byte lane only so ce2_n stays high
    initial begin
        {hostAddr, hostDataIn} = 32'h0000_ffff;
        {ce1_n, ce2_n, regSel_n, memRd_n, memWr_n, ioRd_n, ioWr_n} = 7'h7f;
        obsValid = 1'b0;
    end

    // Strobes are held from launch to the sampling edge, then all released
    task automatic access(input logic io, input logic wr, input logic attr,
            input logic [15:0] addr, input logic [15:0] wdata);
        @(posedge core_clk);
        hostAddr <= addr;
        hostDataIn <= wr ? wdata : ~hostDataIn;
        ce1_n <= 1'b0;
        regSel_n <= ~(attr | io);
        {memRd_n, memWr_n} <= {io | wr, io | ~wr};
        {ioRd_n, ioWr_n} <= {~io | wr, ~io | ~wr};
        repeat (2) @(posedge core_clk);
        obsValid <= 1'b1;
        @(posedge core_clk);
        obsValid <= 1'b0;
        {ce1_n, memRd_n, memWr_n, ioRd_n, ioWr_n} <= 5'h1f;
        regSel_n <= 1'b1;
        // Released data never keeps the last value
        hostDataIn <= ~hostDataIn;
    endtask
endmodule

// ---- pc_card_host_interface_decode_tb.sv ----
// Self-checking bench for the card-mode host interface decoder.
// Assumes the socket model in pc_card_host_model.sv drives the card bus.
`timescale 1ns/100ps
module pc_card_host_interface_decode_tb
    import pc_card_pkg::*;
;
    localparam logic [2:0] AR = 3'b001, AW = 3'b011, IR = 3'b100, IW = 3'b110;
    localparam logic [2:0] CR = 3'b000, CW = 3'b010;
    logic core_clk, reset_n, cardModeStrap, sharedMemMode, flashWriteEnable;
    logic eepromPresent, sleep_n, netTpSelect, sharedMemMatch, irqReq;
    logic coreReady, isaIo16Req, isaNotReady, obsValid;
    logic ce1_n, ce2_n, regSel_n, memRd_n, memWr_n, ioRd_n, ioWr_n;
    logic [ADDR_W-1:0] hostAddr, localAddr, addr;
    logic [DATA_W-1:0] hostDataIn, hostDataOut, ioRdData, ioWrData;
    logic [DATA_W-1:0] localRdData, rd;
    logic hostDataOe_n, waitOut_n, waitOe_n, iois16Out_n, iois16Oe_n;
    logic inpack_n, cardIreq_n, ioRdActive, ioWrStb, cfgLoadEn, sleepReq;
    logic tpActive, auiActive, cardMode, ioEnable, flashCs_n, flashWe_n;
    logic sramCs_n, sramWe_n, localOe_n;
    logic [ISA_IRQ_W-1:0] isaIrqOut, isaIrqOe_n, isaIrqReq;
    logic [REG_ADDR_W-1:0] ioRegAddr;
    logic [31:0] obsWord;
    logic [63:0] note;
    logic [63:0] expQ[$];
    logic [7:0] ccrVal[4];
    int miscompares, checksDone, wrPulses, cycles;
    integer seed;

    pc_card_host_interface_decode dut_u (.*);
    pc_card_host_model host_u (.*);

    // One word holding the I/O register address and the card's bus answers in a cycle
    assign obsWord = {ioRegAddr, hostDataOe_n, waitOe_n, inpack_n, iois16Oe_n,
        flashCs_n, flashWe_n, sramCs_n, sramWe_n, localOe_n, waitOut_n,
        iois16Out_n, hostDataOut};

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checksDone++;
        if (seen !== want) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic printVerdict();
        if (miscompares == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Notes the expected answer first, then runs the host cycle
    task automatic cyc(input logic [2:0] kind, input logic [15:0] a,
            input logic [15:0] wdata, input logic [31:0] mask,
            input logic [31:0] want);
        expQ.push_back({mask, want & mask});
        host_u.access(kind[2], kind[1], kind[0], a, wdata);
    endtask

    // Strap is only taken right after release, so it changes under reset
    task automatic doReset(input logic strap);
        @(posedge core_clk);
        reset_n <= 1'b0;
        cardModeStrap <= strap;
        repeat (6) @(posedge core_clk);
        check(32'(cfgLoadEn), 32'(eepromPresent));
        reset_n <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask

    // Takes the oldest note whenever the host marks a settled answer
    always @(posedge core_clk) begin
        if (obsValid === 1'b1 && expQ.size() > 0) begin
            note = expQ.pop_front();
            check(obsWord & note[63:32], note[31:0]);
            check({localAddr, ioWrData}, {hostAddr, hostDataIn});
        end
    end

    // A write strobe counts once for each cycle it is high
    always @(posedge core_clk) begin
        if (ioWrStb === 1'b1) begin
            wrPulses++;
        end
    end

    // Hang guard, well above the roughly 135 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            printVerdict();
        end
    end

    initial begin
        seed = 34;
        reset_n = 1'b0;
        {cardModeStrap, sharedMemMode, flashWriteEnable, eepromPresent} = 4'h9;
        {sleep_n, netTpSelect, sharedMemMatch, irqReq} = 4'he;
        {coreReady, isaIo16Req, isaNotReady} = 3'b100;
        isaIrqReq = 8'($random(seed));
        ioRdData = 16'($random(seed));
        localRdData = 16'($random(seed));
        doReset(1'b1);
        check(32'(cardMode), 32'h1);
        check(32'(ioEnable), 32'h0);
        check(32'(isaIrqOe_n), 32'hfd);
        check(32'(isaIrqOut), 32'(isaIrqReq | 8'h02));
        check(32'({tpActive, auiActive}), 32'h2);
        {sleep_n, netTpSelect, irqReq} <= 3'b001;
        repeat (3) @(posedge core_clk);
        check(32'({sleepReq, tpActive, auiActive, cardIreq_n}), 32'ha);
        // I/O before configuration: no answer at all
        cyc(IR, 16'h0300, 16'h0000, 32'h0780_0000, 32'h0780_0000);
        cyc(IW, 16'h0302, 16'h1234, 32'h0780_0000, 32'h0780_0000);
        check(32'(wrPulses), 32'h0);
        // Configuration registers, written high to low, read back low first
        for (int i = 3; i >= 0; i--) begin
            ccrVal[i] = 8'($random(seed)) & 8'hfe;
            cyc(AW, CARD_CONFIG_OPTION_OFS + 16'(2 * i), {8'h00, ccrVal[i]},
                32'h0460_0000, 32'h0460_0000);
        end
        for (int i = 0; i < CCR_COUNT; i++) begin
            cyc(AR, CARD_CONFIG_OPTION_OFS + 16'(2 * i), 16'h0000,
                32'h0450_ffff, 32'h0050_0000 | 32'(ccrVal[i]));
        end
        check(32'(ioEnable), 32'h0);
        // Odd attribute bytes select nothing and change nothing
        cyc(AW, 16'h03f1, 16'h00ff, 32'h0460_0000, 32'h0460_0000);
        cyc(AR, 16'h03f1, 16'h0000, 32'h0440_0000, 32'h0440_0000);
        cyc(AR, 16'h03f0, 16'h0000, 32'h0000_ffff, 32'(ccrVal[0]));
        ccrVal[0] = 8'($random(seed)) | 8'h01;
        cyc(AW, 16'h03f0, {8'h00, ccrVal[0]}, 32'h0460_0000,
            32'h0460_0000);
        cyc(AR, 16'h03f0, 16'h0000, 32'h0000_003f,
            32'(ccrVal[0] & 8'h3f));
        check(32'(ioEnable), 32'h1);
        // Enabled I/O: only the low five address bits pick the register
        for (int i = 0; i < 4; i++) begin
            addr = 16'($random(seed));
            rd = 16'($random(seed));
            ioRdData <= rd;
            cyc(IR, addr, 16'h0000, 32'hff81_ffff,
                {addr[4:0], 11'h000, rd});
        end
        cyc(IW, 16'h0310, 16'h5a5a, 32'h0400_0000, 32'h0400_0000);
        cyc(IW, 16'h0312, 16'ha5a5, 32'h0400_0000, 32'h0400_0000);
        check(32'(wrPulses), 32'h2);
        // Flash behind attribute space, writes gated by the enable
        rd = 16'($random(seed));
        localRdData <= rd;
        cyc(AR, 16'h0000, 16'h0000, 32'h0450_00ff,
            32'h0010_0000 | 32'(rd[7:0]));
        for (int w = 0; w < 2; w++) begin
            flashWriteEnable <= w[0];
            cyc(AW, 16'h0010, 16'h00c3, 32'h0060_0000,
                (w == 1) ? 32'h0 : 32'h0020_0000);
        end
        // Common memory: SRAM on a shared-memory miss, flash on a match
        rd = 16'($random(seed));
        localRdData <= rd;
        {sharedMemMode, sharedMemMatch} <= 2'b10;
        cyc(CW, 16'h0040, 16'h3c3c, 32'h0478_0000, 32'h0460_0000);
        cyc(CR, 16'h0040, 16'h0000, 32'h0454_ffff,
            32'h0040_0000 | 32'(rd));
        sharedMemMatch <= 1'b1;
        cyc(CR, 16'h0020, 16'h0000, 32'h06d7_ffff,
            32'h0092_0000 | 32'(rd));
        // Strap low: open-drain style ready and 16-bit lines
        isaNotReady <= 1'b1;
        doReset(1'b0);
        check(32'({cardMode, waitOe_n, iois16Oe_n}), 32'h1);
        check({16'h0, isaIrqOut, isaIrqOe_n}, {16'h0, isaIrqReq, 8'h00});
        check(32'(expQ.size()), 32'h0);
        printVerdict();
    end
endmodule
